// ### eep_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module eep_bus_master (
  // system
  input  wire logic       clk,
  // bus
  input  wire logic       sda,
  output var  logic       scl,
  output var  logic       sdaLow,
  // received byte
  output var  logic [7:0] rdByte,
  output var  logic       rdStrobe
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdByte = 8'h00;
    rdStrobe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // 160 ns bit; data moves only while scl is low
  task automatic clkBit(input logic b, output logic s);
    w(4);
    sdaLow = !b;
    w(16);
    scl = 1'b1;
    w(20);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic edges(input logic a, input logic b);
    w(4);
    sdaLow = a;
    w(16);
    scl = 1'b1;
    w(20);
    sdaLow = b;
    w(20);
  endtask
  task automatic start();
    edges(1'b0, 1'b1);
    scl = 1'b0;
  endtask
  task automatic stop();
    edges(1'b1, 1'b0);
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clkBit(d[i], s);
    clkBit(1'b1, s);
    ack = !s;
  endtask
  // a withheld ack ends the read; the caller then sends stop
  task automatic getByte(input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clkBit(1'b1, s);
      rdByte[i] = s;
    end
    clkBit(!mack, s);
    rdStrobe = 1'b1;
    w(1);
    rdStrobe = 1'b0;
  endtask
endmodule // eep_bus_master
`default_nettype wire

// ### eep_pkg.sv
package eep_pkg;
  // memory geometry
  localparam int unsigned EEP_ADDR_W     = 7;
  localparam int unsigned EEP_DEPTH      = 128;
  localparam int unsigned EEP_PAGE_BYTES = 16;
  localparam int unsigned EEP_PAGE_LSB_W = 4;
  // slave address byte layout
  localparam logic [3:0] EEP_DEV_CODE    = 4'ha;
  localparam int unsigned EEP_CODE_MSB   = 7;
  localparam int unsigned EEP_CODE_LSB   = 4;
  localparam int unsigned EEP_RW_BIT     = 0;
  // reset values
  localparam logic [6:0] EEP_ADDR_RST    = 7'h00;
  localparam logic [7:0] EEP_MEM_RST     = 8'hff;
  // timing
  localparam int unsigned EEP_CLK_MHZ    = 250;
  localparam int unsigned EEP_TWR_MS     = 10;
  localparam int unsigned EEP_TWR_CYC    = EEP_TWR_MS * 1000 * EEP_CLK_MHZ;

  typedef enum logic [2:0] {
    EEP_IDLE    = 3'b000,
    EEP_DEVADDR = 3'b001,
    EEP_WORD    = 3'b011,
    EEP_WDATA   = 3'b010,
    EEP_RDATA   = 3'b110,
    EEP_RACK    = 3'b111,
    EEP_SKIP    = 3'b101
  } eep_state_e;

  // open-drain data pin seen from the device
  typedef struct packed {
    logic out;
    logic oe;
  } eep_sda_drv_s;
endpackage

// ### eep_slave.sv
`timescale 1ns/10ps
`default_nettype none
module eep_slave #(
  parameter int unsigned TWR_CYCLES = eep_pkg::EEP_TWR_CYC
) (
  // system
  input  wire logic         clk,
  input  wire logic         reset_n,
  // two-wire bus
  input  wire logic         sclIn,
  input  wire logic         sdaIn,
  output var eep_pkg::eep_sda_drv_s sdaDrv,
  // write protect
  input  wire logic         transmit_only_clock_pin,
  // status
  output logic              busy
);
  import eep_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic [1:0] wpSync;
  logic       sclPrev;
  logic       sdaPrev;

  // bus clock; resets to the idle level so no false edge follows reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclSync <= 2'h3;
    end else begin
      sclSync <= {sclSync[0], sclIn};
    end
  end

  // bus data; same idle level as the pull-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], sdaIn};
    end
  end

  // write enable pin; starts protected until the pin is seen high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wpSync <= 2'h0;
    end else begin
      wpSync <= {wpSync[0], transmit_only_clock_pin};
    end
  end

  // one cycle of history for edge and condition detection
  // only the second synchroniser flop is read from here on
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign scl       = sclSync[1];
  assign sda       = sdaSync[1];
  assign sclRise   = scl & ~sclPrev;
  assign sclFall   = ~scl & sclPrev;
  assign startCond = scl & sclPrev & sdaPrev & ~sda;
  assign stopCond  = scl & sclPrev & ~sdaPrev & sda;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the page buffer collects bytes until the stop; only bytes that
  // arrived are committed, so a short page leaves its neighbours alone
  logic [7:0] memArray [EEP_DEPTH];
  logic [7:0] pageBuf  [EEP_PAGE_BYTES];
  logic [EEP_PAGE_BYTES-1:0] pageValid;

  function automatic logic [6:0] pageInc(input logic [6:0] a);
    pageInc = {a[6:EEP_PAGE_LSB_W],
               a[EEP_PAGE_LSB_W-1:0] + 4'h1};
  endfunction

  function automatic logic isDevAddr(input logic [7:0] b);
    isDevAddr = b[EEP_CODE_MSB:EEP_CODE_LSB] == EEP_DEV_CODE;
  endfunction

  // ----------------------------------------------------------------
  // bit engine and protocol state
  // ----------------------------------------------------------------
  // bits are taken on a bus clock rise and the line is moved on a
  // fall, so the drive never changes while the bus clock is high
  eep_state_e stateReg;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic [6:0] addrReg;
  logic       ackPhase;
  logic       ackDrive;
  logic       dataDrive;
  logic [7:0] txByte;
  logic       wrPending;
  logic       progGo;
  logic [23:0] twrCnt;

  logic       devMatch;
  assign devMatch = isDevAddr(shiftReg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg  <= EEP_IDLE;
      bitCnt    <= 4'h0;
      shiftReg  <= 8'h00;
      ackPhase  <= 1'b0;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b0;
      txByte    <= 8'h00;
      addrReg   <= EEP_ADDR_RST;
      wrPending <= 1'b0;
      pageValid <= '0;
    end else if (busy) begin
      // interface disabled while programming; line released
      stateReg  <= EEP_IDLE;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b0;
      wrPending <= 1'b0;
      pageValid <= '0;
    end else if (startCond) begin
      stateReg  <= EEP_DEVADDR;
      bitCnt    <= 4'h0;
      ackPhase  <= 1'b0;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b0;
    end else if (stopCond) begin
      stateReg  <= EEP_IDLE;
      ackDrive  <= 1'b0;
      dataDrive <= 1'b0;
      wrPending <= 1'b0;
      pageValid <= '0;
    end else if (sclRise && !ackPhase) begin
      unique case (stateReg)
        EEP_DEVADDR, EEP_WORD, EEP_WDATA: begin
          shiftReg <= {shiftReg[6:0], sda};
          bitCnt   <= bitCnt + 4'h1;
        end
        EEP_RDATA: bitCnt <= bitCnt + 4'h1;
        default: ;
      endcase
    end else if (sclRise && ackPhase && stateReg == EEP_RACK) begin
      // master ack sampled; no ack ends the read
      if (sda) begin
        stateReg <= EEP_SKIP;
      end else begin
        stateReg <= EEP_RDATA;
      end
    end else if (sclFall) begin
      if (ackPhase) begin
        // end of ninth clock
        ackPhase <= 1'b0;
        ackDrive <= 1'b0;
        bitCnt   <= 4'h0;
        if (stateReg == EEP_RDATA) begin
          txByte    <= memArray[addrReg];
          addrReg   <= addrReg + 7'h01;
          dataDrive <= 1'b1;
        end
      end else if (bitCnt == 4'h8) begin
        ackPhase <= 1'b1;
        unique case (stateReg)
          EEP_DEVADDR: begin
            if (!devMatch) begin
              stateReg <= EEP_SKIP;
            end else if (shiftReg[EEP_RW_BIT]) begin
              stateReg <= EEP_RDATA;
              ackDrive <= 1'b1;
            end else begin
              stateReg <= EEP_WORD;
              ackDrive <= 1'b1;
            end
          end
          EEP_WORD: begin
            addrReg  <= shiftReg[6:0];
            stateReg <= EEP_WDATA;
            ackDrive <= 1'b1;
          end
          EEP_WDATA: begin
            pageBuf[addrReg[EEP_PAGE_LSB_W-1:0]]   <= shiftReg;
            pageValid[addrReg[EEP_PAGE_LSB_W-1:0]] <= 1'b1;
            addrReg   <= pageInc(addrReg);
            wrPending <= 1'b1;
            ackDrive  <= 1'b1;
          end
          EEP_RDATA: begin
            // own data byte sent; release and watch master ack
            dataDrive <= 1'b0;
            stateReg  <= EEP_RACK;
          end
          default: ackPhase <= 1'b0;
        endcase
      end else if (stateReg == EEP_RDATA && dataDrive) begin
        txByte <= {txByte[6:0], 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // programming cycle
  // ----------------------------------------------------------------
  // protection sampled at the stop only; a later drop has no effect
  assign progGo = stopCond && !busy && wrPending && wpSync[1];

  // busy stands for exactly TWR_CYCLES clocks after the stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else if (progGo) begin
      busy <= 1'b1;
    end else if (busy && twrCnt == 24'h000000) begin
      busy <= 1'b0;
    end
  end

  // remaining programming time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      twrCnt <= 24'h000000;
    end else if (progGo) begin
      twrCnt <= 24'(TWR_CYCLES - 1);
    end else if (busy && twrCnt != 24'h000000) begin
      twrCnt <= twrCnt - 24'h000001;
    end
  end

  // array initial contents are undefined after reset
  always_ff @(posedge clk) begin
    if (progGo) begin
      for (int i = 0; i < EEP_PAGE_BYTES; i++) begin
        if (pageValid[i]) begin
          memArray[{addrReg[6:EEP_PAGE_LSB_W], 4'(i)}] <= pageBuf[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain data pin
  // ----------------------------------------------------------------
  // the pin is only ever pulled low; a one is sent by letting go,
  // which keeps the device safe against a master driving at once
  logic txFirst;
  assign txFirst = dataDrive & ~txByte[7];
  assign sdaDrv  = '{out: 1'b0, oe: ackDrive | txFirst};
endmodule // eep_slave
`default_nettype wire

// ### eep_slave_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module eep_slave_assertions #(parameter int unsigned TWR_CYCLES = 50) (
  // system
  input wire logic                  clk,
  input wire logic                  reset_n,
  // pins and status
  input wire logic                  sclIn,
  input wire logic                  sdaIn,
  input wire eep_pkg::eep_sda_drv_s sdaDrv,
  input wire logic                  transmit_only_clock_pin,
  input wire logic                  busy
);
  import eep_pkg::*;
  logic [31:0] busyCnt_reg;
  logic [7:0]  lowCnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busyCnt_reg <= 32'h0;
    else busyCnt_reg <= busy ? busyCnt_reg + 32'h1 : 32'h0;
  end
  // clocks since scl went low; drive may only move shortly after a fall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lowCnt_reg <= 8'h0;
    else if (sclIn) lowCnt_reg <= 8'h0;
    else if (lowCnt_reg != 8'hff) lowCnt_reg <= lowCnt_reg + 8'h1;
  end
  a_busy_quiet: assert property (busy |-> !sdaDrv.oe)
    else $error("data line pulled while programming");
  a_open_drain: assert property (sdaDrv.out == 1'b0)
    else $error("data line driven high");
  a_drive_low: assert property ($changed(sdaDrv.oe) |->
    !sclIn && lowCnt_reg < 8'h0c) else $error("drive moved off scl fall");
  a_start_free: assert property (sclIn && $fell(sdaIn) |->
    !sdaDrv.oe [*8]) else $error("line pulled right after start");
  a_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("programming ended at once");
  a_busy_len: assert property ($fell(busy) |->
    busyCnt_reg + 32'h1 >= TWR_CYCLES && busyCnt_reg <= TWR_CYCLES + 1)
    else $error("programming length wrong");
  a_busy_stop: assert property ($rose(busy) |-> sclIn && sdaIn)
    else $error("programming began off a stop");
  a_busy_wp: assert property ($rose(busy) |->
    $past(transmit_only_clock_pin, 8)) else $error("protected write ran");
endmodule // eep_slave_assertions
bind eep_slave eep_slave_assertions #(.TWR_CYCLES(TWR_CYCLES)) i_chk (
  .clk(clk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn), .busy(busy),
  .sdaDrv(sdaDrv), .transmit_only_clock_pin(transmit_only_clock_pin));
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import eep_pkg::*;
  logic         clk = 1'b0, reset_n, wp, scl, sdaLow, busy, ack, rdStrobe;
  logic [7:0]   rdByte, mem [128], expQ [$];
  logic [6:0]   ptr;
  eep_sda_drv_s sdaDrv;
  int           error_cnt = 0, check_count = 0, cycles = 0;
  int           seed = 32'h31984b8f;
  wire logic    sda = !(sdaLow || sdaDrv.oe);
  always #2 clk = ~clk;
  eep_slave #(.TWR_CYCLES(1000)) i_eep_slave (.clk(clk), .reset_n(reset_n),
    .sclIn(scl), .sdaIn(sda), .sdaDrv(sdaDrv),
    .transmit_only_clock_pin(wp), .busy(busy));
  eep_bus_master i_eep_bus_master (.clk(clk), .sda(sda), .scl(scl),
    .sdaLow(sdaLow), .rdByte(rdByte), .rdStrobe(rdStrobe));
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chkByte(input string n, input logic [7:0] e, v);
    check_count++;
    if (v !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic chkBit(input string n, input logic e, v);
    chkByte(n, {7'h00, e}, {7'h00, v});
  endtask
  // don't-care address bits are random
  function automatic logic [7:0] devA(input logic rw);
    return {EEP_DEV_CODE, 3'($random(seed)), rw};
  endfunction
  task automatic put(input logic [7:0] b, input logic e);
    i_eep_bus_master.sendByte(b, ack);
    chkBit("acknowledge", e, ack);
  endtask
  task automatic wr(input logic [6:0] a, input int n);
    logic [7:0] d;
    i_eep_bus_master.start();
    put(devA(1'b0), 1'b1);
    put({1'b0, a}, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      put(d, 1'b1);
      if (wp) mem[{a[6:4], 4'(a[3:0] + i)}] = d;
    end
    ptr = {a[6:4], 4'(a[3:0] + n)};
    i_eep_bus_master.stop();
  endtask
  task automatic poll();
    chkBit("busy", 1'b1, busy);
    for (int n = 0; n < 9; n++) begin
      i_eep_bus_master.start();
      i_eep_bus_master.sendByte(devA(1'b0), ack);
      if (n == 0) chkBit("busy ack", 1'b0, ack);
      if (ack) break;
    end
    chkBit("ready ack", 1'b1, ack);
    i_eep_bus_master.stop();
  endtask
  task automatic rd(input int n);
    i_eep_bus_master.start();
    put(devA(1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(mem[ptr]);
      ptr++;
      i_eep_bus_master.getByte(i < n - 1);
    end
    i_eep_bus_master.stop();
  endtask
  task automatic sel(input logic [6:0] a, input int n);
    i_eep_bus_master.start();
    put(devA(1'b0), 1'b1);
    put({1'b0, a}, 1'b1);
    ptr = a;
    rd(n);
  endtask
  always @(posedge rdStrobe) begin
    chkByte("read data", expQ.pop_front(), rdByte);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      close_out();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    wp = 1'b1;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    wr(7'h7f, 1);
    poll();
    wr(7'h0e, 18);
    poll();
    rd(1);
    sel(7'h7f, 17);
    wp = 1'b0;
    wr(7'h05, 2);
    chkBit("busy", 1'b0, busy);
    sel(7'h05, 1);
    i_eep_bus_master.start();
    put(8'h52, 1'b0);
    put(devA(1'b0), 1'b0);
    i_eep_bus_master.stop();
    close_out();
  end
endmodule // testbench
`default_nettype wire
